// [core/sram_port_pkg.sv]
package sram_port_pkg;
  // ----------------------------------------
  // Organisation, fixed at the wide variant
  // ----------------------------------------
  localparam int ADDR_W = 19;
  localparam int DATA_W = 36;
  localparam int BYTE_W = 9;
  localparam int BYTES = 4;
  localparam int CHK_W = 6;
  localparam int CODE_W = 42;
  localparam int MEM_WORDS = 524288;
  // The narrow variant would be 1M words of 18 bits, 2 lanes
  localparam int NARROW_ADDR_W = 20;
  localparam int NARROW_DATA_W = 18;

  // ----------------------------------------
  // Burst counter and data buffer
  // ----------------------------------------
  localparam int BURST_W = 2;
  localparam logic [BURST_W-1:0] BURST_START = 2'h0;
  localparam logic [BURST_W-1:0] BURST_STEP = 2'h1;
  localparam logic ORDER_INTERLEAVED = 1'b1;
  localparam logic ORDER_LINEAR = 1'b0;
  localparam int FIFO_DEPTH = 8;

  typedef logic [ADDR_W-1:0] addr_t;
  typedef logic [DATA_W-1:0] data_t;
  typedef logic [CODE_W-1:0] code_t;
  typedef logic [BYTES-1:0] lanes_t;
  typedef logic [BURST_W-1:0] burst_t;
endpackage

// [core/fifo_if.sv]
interface fifo_if #(parameter int W = 8) ();
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// [core/stream_fifo.sv]
module stream_fifo #(
  parameter int WIDTH = 36,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Filling and draining sides
  fifo_if.snk fill,
  fifo_if.src drain
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = PW + 1;

  logic [WIDTH-1:0] store [DEPTH];
  logic [PW-1:0] wrPtr_r;
  logic [PW-1:0] rdPtr_r;
  logic [CW-1:0] count_r;
  logic empty;
  logic full;
  logic push;
  logic pop;

  // ----------------------------------------
  // Fall-through when empty keeps latency
  // ----------------------------------------
  assign empty = (count_r == '0);
  assign full = (count_r == CW'(DEPTH));
  assign fill.ready = !full;
  assign drain.valid = empty ? fill.valid : 1'b1;
  assign drain.data = empty ? fill.data : store[rdPtr_r];
  assign push = fill.valid && !full && !(empty && drain.ready);
  assign pop = drain.ready && !empty;

  always_ff @(posedge mclk) begin
    if (push) begin
      store[wrPtr_r] <= fill.data;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      count_r <= '0;
    end else begin
      if (push) begin
        wrPtr_r <= PW'(wrPtr_r + 1'b1);
      end
      if (pop) begin
        rdPtr_r <= PW'(rdPtr_r + 1'b1);
      end
      count_r <= CW'(count_r + CW'(push) - CW'(pop));
    end
  end
endmodule // stream_fifo

// [core/flow_through_burst_sram_port.sv]
module flow_through_burst_sram_port (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Address and burst control
  input wire sram_port_pkg::addr_t address,
  input wire logic proc_addr_strobe_n,
  input wire logic ctrl_addr_strobe_n,
  input wire logic burst_step_n,
  input wire logic burst_order_sel,
  // Chip enables
  input wire logic pipeline_chip_sel_n,
  input wire logic depth_chip_sel_hi,
  input wire logic depth_chip_sel_n,
  // Write controls
  input wire sram_port_pkg::lanes_t byte_select_n,
  input wire logic byte_write_gate_n,
  input wire logic global_write_n,
  // Asynchronous controls
  input wire logic output_enable_n,
  input wire logic sleep_request,
  // Shared data bus
  input wire sram_port_pkg::data_t dqIn,
  output logic [sram_port_pkg::DATA_W-1:0] dqOut,
  output logic dqOen
);
  import sram_port_pkg::*;

  // ----------------------------------------
  // Error correction helpers
  // ----------------------------------------
  function automatic logic [CHK_W-1:0] eccSyndrome(code_t c);
    logic [CHK_W-1:0] s;
    s = '0;
    for (int p = 1; p <= CODE_W; p++) begin
      if (c[p-1]) begin
        s = s ^ CHK_W'(p);
      end
    end
    return s;
  endfunction

  function automatic code_t eccEncode(data_t d);
    code_t c;
    logic [CHK_W-1:0] s;
    int k;
    c = '0;
    k = 0;
    for (int p = 1; p <= CODE_W; p++) begin
      if ((p & (p - 1)) != 0) begin
        c[p-1] = d[k];
        k++;
      end
    end
    s = eccSyndrome(c);
    for (int i = 0; i < CHK_W; i++) begin
      c[(1 << i) - 1] = s[i];
    end
    return c;
  endfunction

  // Corrects any single flipped bit; a double error can flip a third bit instead
  function automatic data_t eccDecode(code_t cIn);
    code_t c;
    data_t d;
    logic [CHK_W-1:0] s;
    int k;
    c = cIn;
    d = '0;
    k = 0;
    s = eccSyndrome(c);
    if (s != '0 && int'(s) <= CODE_W) begin
      c[int'(s) - 1] = !c[int'(s) - 1];
    end
    for (int p = 1; p <= CODE_W; p++) begin
      if ((p & (p - 1)) != 0) begin
        d[k] = c[p-1];
        k++;
      end
    end
    return d;
  endfunction

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  code_t mem [MEM_WORDS];
  addr_t baseAddr_r;
  burst_t burstCnt_r;
  burst_t burstLow;
  addr_t curAddr;
  logic selected_r;
  logic strobe;
  logic chipSel;
  logic isWrite;
  logic accept;
  lanes_t laneWrite;
  data_t oldData;
  data_t readData;
  data_t merged;
  code_t curCode;
  logic sleepMeta_r;
  logic sleepSync_r;
  data_t dqOut_r;
  logic readOn_r;

  fifo_if #(.W(DATA_W)) rdFill ();
  fifo_if #(.W(DATA_W)) rdDrain ();

  // ----------------------------------------
  // Strobes, selects and write decode
  // ----------------------------------------
  assign strobe = !proc_addr_strobe_n || !ctrl_addr_strobe_n;
  assign chipSel = !pipeline_chip_sel_n && depth_chip_sel_hi
    && !depth_chip_sel_n;
  // Full buffer refuses the cycle rather than drop read data
  assign accept = rdFill.ready;

  for (genvar l = 0; l < BYTES; l++) begin : g_lane
    assign laneWrite[l] = !global_write_n
      || (!byte_write_gate_n && !byte_select_n[l]);
    assign merged[l*BYTE_W +: BYTE_W] = laneWrite[l]
      ? dqIn[l*BYTE_W +: BYTE_W] : oldData[l*BYTE_W +: BYTE_W];
  end

  assign isWrite = |laneWrite;

  // ----------------------------------------
  // Burst address generation
  // ----------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      baseAddr_r <= '0;
      selected_r <= 1'b0;
    end else if (strobe && accept) begin
      baseAddr_r <= address;
      selected_r <= chipSel;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      burstCnt_r <= BURST_START;
    end else if (strobe && accept) begin
      burstCnt_r <= BURST_START;
    end else if (selected_r && !burst_step_n && accept) begin
      burstCnt_r <= burstCnt_r + BURST_STEP;
    end
  end

  // Two-bit sum wraps inside the four-word group by itself
  assign burstLow = (burst_order_sel == ORDER_INTERLEAVED)
    ? (baseAddr_r[BURST_W-1:0] ^ burstCnt_r)
    : burst_t'(baseAddr_r[BURST_W-1:0] + burstCnt_r);
  assign curAddr = {baseAddr_r[ADDR_W-1:BURST_W], burstLow};

  // ----------------------------------------
  // Array access with correction
  // ----------------------------------------
  assign curCode = mem[curAddr];
  assign oldData = eccDecode(curCode);
  assign readData = oldData;

  // Partial writes merge with the corrected old word
  always_ff @(posedge mclk) begin
    if (selected_r && isWrite && accept) begin
      mem[curAddr] <= eccEncode(merged);
    end
  end

  assign rdFill.valid = selected_r && !isWrite;
  assign rdFill.data = readData;
  assign rdDrain.ready = !sleepSync_r;

  stream_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_rdFifo (
    .mclk(mclk),
    .rst_n(rst_n),
    .fill(rdFill),
    .drain(rdDrain)
  );

  // ----------------------------------------
  // Sleep synchroniser and output stage
  // ----------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sleepMeta_r <= 1'b0;
      sleepSync_r <= 1'b0;
    end else begin
      sleepMeta_r <= sleep_request;
      sleepSync_r <= sleepMeta_r;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      dqOut_r <= '0;
      readOn_r <= 1'b0;
    end else if (rdDrain.ready) begin
      readOn_r <= rdDrain.valid;
      if (rdDrain.valid) begin
        dqOut_r <= rdDrain.data;
      end
    end
  end

  assign dqOut = dqOut_r;
  // Drivers drop at once on either pin, no edge needed
  assign dqOen = output_enable_n || sleep_request || !readOn_r;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  sequence s_load;
    strobe && accept;
  endsequence

  sequence s_stepReq;
    selected_r && !strobe && accept && !burst_step_n;
  endsequence

  sequence s_bypassRead;
    rdDrain.ready && rdDrain.valid && rdFill.valid
      && rdDrain.data == readData;
  endsequence

  property p_strobeLoad;
    s_load |=> baseAddr_r == $past(address) && burstCnt_r == BURST_START;
  endproperty
  a_strobeLoad: assert property (p_strobeLoad)
    else $error("address not loaded on strobe");

  property p_ctrlOnly;
    proc_addr_strobe_n && !ctrl_addr_strobe_n && accept && chipSel
      |=> selected_r && baseAddr_r == $past(address);
  endproperty
  a_ctrlOnly: assert property (p_ctrlOnly)
    else $error("controller strobe did not start burst");

  property p_noStrobeHold;
    !strobe |=> $stable(baseAddr_r) && $stable(selected_r);
  endproperty
  a_noStrobeHold: assert property (p_noStrobeHold)
    else $error("address changed without strobe");

  property p_step;
    s_stepReq |=> burstCnt_r == burst_t'($past(burstCnt_r) + BURST_STEP);
  endproperty
  a_step: assert property (p_step)
    else $error("burst counter did not step");

  property p_stepHold;
    !strobe && burst_step_n |=> $stable(burstCnt_r);
  endproperty
  a_stepHold: assert property (p_stepHold)
    else $error("burst counter moved without step");

  property p_upperFixed;
    s_stepReq ##1 s_stepReq |=>
      curAddr[ADDR_W-1:BURST_W] == $past(curAddr[ADDR_W-1:BURST_W], 2);
  endproperty
  a_upperFixed: assert property (p_upperFixed)
    else $error("upper burst address changed");

  property p_order;
    burst_order_sel |-> burstLow == (baseAddr_r[BURST_W-1:0] ^ burstCnt_r);
  endproperty
  a_order: assert property (p_order)
    else $error("interleaved order wrong");

  property p_firstWord;
    s_bypassRead |=> readOn_r && dqOut_r == $past(readData);
  endproperty
  a_firstWord: assert property (p_firstWord)
    else $error("read word late or wrong");

  property p_quiet;
    output_enable_n || sleep_request |-> dqOen;
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("bus driven while disabled");

  property p_sleepHold;
    sleepSync_r [*2] |-> $stable(dqOut_r);
  endproperty
  a_sleepHold: assert property (p_sleepHold)
    else $error("output moved during sleep");

  property p_globalWrite;
    selected_r && accept && !global_write_n
      |=> eccDecode(mem[$past(curAddr)]) == $past(dqIn);
  endproperty
  a_globalWrite: assert property (p_globalWrite)
    else $error("global write lost a byte");

  property p_noGate;
    selected_r && global_write_n && byte_write_gate_n
      |=> mem[$past(curAddr)] == $past(curCode);
  endproperty
  a_noGate: assert property (p_noGate)
    else $error("write without gate");
endmodule // flow_through_burst_sram_port

// [test/cpu_bus_model.sv]
// ----------------------------------------
// Processor side of the burst port
// ----------------------------------------
module cpu_bus_model (
  // Clock
  input wire logic mclk,
  // Address and burst control
  output sram_port_pkg::addr_t address,
  output logic proc_addr_strobe_n,
  output logic ctrl_addr_strobe_n,
  output logic burst_step_n,
  output logic burst_order_sel,
  // Chip enables
  output logic pipeline_chip_sel_n,
  output logic depth_chip_sel_hi,
  output logic depth_chip_sel_n,
  // Write controls and data
  output sram_port_pkg::lanes_t byte_select_n,
  output logic byte_write_gate_n,
  output logic global_write_n,
  output sram_port_pkg::data_t dqIn
);
  timeunit 1ns;
  timeprecision 1ns;
  import sram_port_pkg::*;
  initial begin
    {proc_addr_strobe_n, ctrl_addr_strobe_n, burst_step_n} = 3'h7;
    {burst_order_sel, pipeline_chip_sel_n, depth_chip_sel_hi} = 3'h7;
    {depth_chip_sel_n, byte_write_gate_n, global_write_n} = 3'h7;
    byte_select_n = 4'hF;
    address = 19'h0;
    dqIn = 36'h0;
  end
  // Strobe cycle, then n access cycles with strobes high; n of 0 leaves the strobe low
  task automatic burst(input bit ctl, input addr_t a, input bit sel,
      input int n, input logic [1:0] wrN, input lanes_t bs, input bit ord,
      input bit hold);
    int k;
    @(negedge mclk);
    k = $urandom % 3;
    proc_addr_strobe_n = ctl;
    ctrl_addr_strobe_n = !ctl;
    address = a;
    burst_order_sel = ord;
    // Deselect breaks one enable at a time
    pipeline_chip_sel_n = !sel && k == 0;
    depth_chip_sel_hi = sel || k != 1;
    depth_chip_sel_n = !sel && k == 2;
    {burst_step_n, global_write_n, byte_write_gate_n} = 3'h7;
    for (int i = 0; i < n; i++) begin
      @(negedge mclk);
      {proc_addr_strobe_n, ctrl_addr_strobe_n} = 2'h3;
      address = addr_t'($urandom);
      burst_step_n = hold && i == 1;
      {global_write_n, byte_write_gate_n} = wrN;
      byte_select_n = bs;
      // Fresh noise each cycle, never a stale word
      dqIn = data_t'({$urandom, $urandom});
    end
  endtask
endmodule // cpu_bus_model

// [test/tb.sv]
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import sram_port_pkg::*;
  logic mclk = 0, rst_n = 0, output_enable_n = 0, sleep_request = 0;
  logic proc_addr_strobe_n, ctrl_addr_strobe_n, burst_step_n;
  logic burst_order_sel, pipeline_chip_sel_n, depth_chip_sel_hi;
  logic depth_chip_sel_n, byte_write_gate_n, global_write_n, dqOen;
  addr_t address, a, base, rb;
  lanes_t byte_select_n;
  data_t dqIn, dqOut;
  data_t mem[addr_t];
  data_t expQ[$];
  int dueQ[$];
  int cyc, miscompares, cmpCount;
  logic on = 0;
  logic nap = 0;
  burst_t cnt;
  logic [1:0] wrTab [4] = '{2'h3, 2'h1, 2'h0, 2'h2};
  always #10 mclk = ~mclk;
  flow_through_burst_sram_port dut (
    .mclk(mclk),
    .rst_n(rst_n),
    .address(address),
    .proc_addr_strobe_n(proc_addr_strobe_n),
    .ctrl_addr_strobe_n(ctrl_addr_strobe_n),
    .burst_step_n(burst_step_n),
    .burst_order_sel(burst_order_sel),
    .pipeline_chip_sel_n(pipeline_chip_sel_n),
    .depth_chip_sel_hi(depth_chip_sel_hi),
    .depth_chip_sel_n(depth_chip_sel_n),
    .byte_select_n(byte_select_n),
    .byte_write_gate_n(byte_write_gate_n),
    .global_write_n(global_write_n),
    .output_enable_n(output_enable_n),
    .sleep_request(sleep_request),
    .dqIn(dqIn),
    .dqOut(dqOut),
    .dqOen(dqOen)
  );
  cpu_bus_model bus (
    .mclk(mclk),
    .address(address),
    .proc_addr_strobe_n(proc_addr_strobe_n),
    .ctrl_addr_strobe_n(ctrl_addr_strobe_n),
    .burst_step_n(burst_step_n),
    .burst_order_sel(burst_order_sel),
    .pipeline_chip_sel_n(pipeline_chip_sel_n),
    .depth_chip_sel_hi(depth_chip_sel_hi),
    .depth_chip_sel_n(depth_chip_sel_n),
    .byte_select_n(byte_select_n),
    .byte_write_gate_n(byte_write_gate_n),
    .global_write_n(global_write_n),
    .dqIn(dqIn)
  );
  // ----------------------------------------
  // Reference model
  // ----------------------------------------
  always @(posedge mclk) begin
    if (rst_n) begin
      cyc++;
      // Open burst still accesses on the edge of a new strobe
      if (on) begin
        a = base;
        a[1:0] = burst_order_sel ? base[1:0] ^ cnt : base[1:0] + cnt;
        if (!global_write_n) begin
          mem[a] = dqIn;
        end else if (!byte_write_gate_n && byte_select_n != 4'hF) begin
          for (int l = 0; l < BYTES; l++) begin
            if (!byte_select_n[l]) mem[a][BYTE_W*l +: BYTE_W] =
                dqIn[BYTE_W*l +: BYTE_W];
          end
        end else begin
          expQ.push_back(mem[a]);
          dueQ.push_back(cyc);
        end
      end
      if (!proc_addr_strobe_n || !ctrl_addr_strobe_n) begin
        on = !pipeline_chip_sel_n && depth_chip_sel_hi && !depth_chip_sel_n;
        base = address;
        cnt = 2'h0;
      end else if (on && !burst_step_n) begin
        cnt++;
      end
    end
  end
  // ----------------------------------------
  // Checks and closing
  // ----------------------------------------
  task chk(input string n, input data_t e, input data_t s);
    cmpCount++;
    if (s !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task tallyAndFinish;
    $display("compares %0d mismatches %0d", cmpCount, miscompares);
    if (miscompares == 0 && cmpCount > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Each word must show exactly on its cycle, and nothing else drives
  always @(negedge mclk) begin
    if (dueQ.size() > 0 && dueQ[0] == cyc) begin
      chk("dqOen", 36'h0, data_t'(dqOen));
      chk("dqOut", expQ.pop_front(), dqOut);
      void'(dueQ.pop_front());
      output_enable_n = 1;
      #2 chk("oe", 36'h1, data_t'(dqOen));
      output_enable_n = 0;
      sleep_request = 1;
      #2 chk("sleep", 36'h1, data_t'(dqOen));
      sleep_request = 0;
    end else if (rst_n) begin
      chk("idle", 36'h1, data_t'(dqOen));
      sleep_request = nap;
    end
  end
  initial begin
    #(20 * 5000);
    miscompares++;
    tallyAndFinish();
  end
  initial begin
    int kind;
    void'($urandom(32'h85607522));
    rb = addr_t'($urandom) & 19'h7FFF0;
    repeat (5) @(posedge mclk);
    chk("rstOen", 36'h1, data_t'(dqOen));
    @(negedge mclk) rst_n = 1;
    // Whole-word fill first, so byte merges never meet unknowns
    for (int g = 0; g < 4; g++) begin
      bus.burst($urandom % 2, addr_t'(rb + 4 * g + $urandom % 4), 1, 4,
          2'h1, 4'hF, $urandom % 2, 0);
    end
    for (int t = 0; t < 60; t++) begin
      kind = $urandom % 4;
      bus.burst($urandom % 2, addr_t'(rb + $urandom % 16),
          $urandom % 5 != 0, 1 + $urandom % 4, wrTab[kind],
          lanes_t'($urandom), $urandom % 2, $urandom % 2);
    end
    bus.burst(0, rb, 0, 0, 2'h3, 4'hF, 0, 0);
    // Nap only once nothing is in flight, no word waits in the buffer
    repeat (2) @(negedge mclk);
    nap = 1;
    repeat (6) @(negedge mclk);
    nap = 0;
    repeat (10) @(negedge mclk);
    chk("pending", 36'h0, data_t'(dueQ.size()));
    tallyAndFinish();
  end
endmodule // tb
